// file: logic/pwm_adc_trigger_select.sv
// Operation
// RULE1: Channel 3 enables zero, down, period, up live in bits 27 to 24.
// RULE2: Channel 2 enables zero, down, period, up live in bits 19 to 16.
// RULE3: Channel 1 enables zero, down, period, up live in bits 11 to 8.
// RULE4: Channel 0 enables zero, down, period, up live in bits 3 to 0.
// RULE5: Enabled zero match triggers the converter in either alignment mode.
// RULE6: Enabled down-count compare match triggers in either alignment mode.
// RULE7: Enabled period match triggers only while the channel is center-aligned.
// RULE8: Enabled up-count compare match triggers only in center-aligned mode.
// RULE9: Edge-aligned channels ignore their period and up-count compare enables.
// RULE10: Control register is read-write at 0x68 and resets to zero.
// RULE11: All enabled events OR into one pulse; reserved bits read zero.
`timescale 1ns/10ps
`default_nettype none
module pwm_adc_trigger_select (
    input  wire logic                            clk_sys,
    input  wire logic                            rst,
    input  wire logic [pwm_trig_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [pwm_trig_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output var  logic [pwm_trig_pkg::DATA_W-1:0] reg_rdata,
    input  wire pwm_trig_pkg::pwm_chan_t         chan [pwm_trig_pkg::NUM_CH],
    output var  logic                            adc_start,
    output var  logic [pwm_trig_pkg::DATA_W-1:0] adc_trig_src
);
    import pwm_trig_pkg::*;

    logic [DATA_W-1:0] trig_ctrl;
    logic [DATA_W-1:0] ev_all;
    logic [TCNT_W-1:0] trig_count;
    logic              hit_ctrl;
    logic              hit_last;
    logic              hit_count;
    logic              any_event;

    assign hit_ctrl  = (reg_addr == TRIG_CTRL0_OFFSET);
    assign hit_last  = (reg_addr == TRIG_LAST_OFFSET);
    assign hit_count = (reg_addr == TRIG_COUNT_OFFSET);
    assign any_event = |ev_all;

    // RULE10 control write path.
    // RULE11 reserved bits dropped.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trig_ctrl <= TRIG_CTRL0_RESET;
        end else if (reg_wr && hit_ctrl) begin
            trig_ctrl <= reg_wdata & TRIG_CTRL0_MASK;
        end
    end

    // Read data stand for exactly one cycle and are zero otherwise, so a
    // stale value can never be mistaken for an answer.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd && hit_ctrl) begin
            reg_rdata <= trig_ctrl;
        end else if (reg_rd && hit_last) begin
            reg_rdata <= adc_trig_src;
        end else if (reg_rd && hit_count) begin
            reg_rdata <= DATA_W'(trig_count);
        end else begin
            reg_rdata <= '0;
        end
    end

    // Unused lanes of the event word stay zero, matching the reserved bits.
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
            logic [EV_W-1:0] ch_en;
            logic [EV_W-1:0] ch_ev;
            // RULE1 channel 3 lane.
            // RULE2 channel 2 lane.
            // RULE3 channel 1 lane.
            // RULE4 channel 0 lane.
            assign ch_en = trig_ctrl[ch*CH_STRIDE +: EV_W];
            trig_event_detect u_detect (
                .clk_sys     (clk_sys),
                .rst         (rst),
                .chan        (chan[ch]),
                .trig_en     (ch_en),
                .event_pulse (ch_ev)
            );
            assign ev_all[ch*CH_STRIDE +: CH_STRIDE] =
                {{(CH_STRIDE-EV_W){1'b0}}, ch_ev};
        end
    endgenerate

    // RULE11 single start pulse.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            adc_start <= 1'b0;
        end else begin
            adc_start <= any_event;
        end
    end

    // The source word keeps the last trigger's causes until the next one.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            adc_trig_src <= '0;
        end else if (any_event) begin
            adc_trig_src <= ev_all;
        end
    end

    // A count that hits the same cycle as a clearing write still counts, so
    // software never loses a trigger while it resets the tally.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trig_count <= TRIG_COUNT_RESET;
        end else if (reg_wr && hit_count) begin
            trig_count <= any_event ? TCNT_W'(1) : TRIG_COUNT_RESET;
        end else if (any_event) begin
            trig_count <= trig_count + TCNT_W'(1);
        end
    end

    sequence s_ctrl_write;
        reg_wr && hit_ctrl;
    endsequence

    sequence s_ctrl_read;
        reg_rd && hit_ctrl;
    endsequence

    sequence s_event_seen;
        any_event ##1 adc_start;
    endsequence

    sequence s_count_read;
        reg_rd && hit_count;
    endsequence

    sequence s_last_read;
        reg_rd && hit_last;
    endsequence

    sequence s_count_clear;
        reg_wr && hit_count;
    endsequence

    a_ctrl_reset_zero : assert property ( // RULE10
        @(posedge clk_sys)
        rst |=> trig_ctrl == TRIG_CTRL0_RESET)
        else $error("control register not zero after reset");

    a_ctrl_write_take : assert property ( // RULE10
        @(posedge clk_sys) disable iff (rst)
        s_ctrl_write |=> trig_ctrl == ($past(reg_wdata) & TRIG_CTRL0_MASK))
        else $error("control write not stored");

    a_ctrl_read_back : assert property ( // RULE10
        @(posedge clk_sys) disable iff (rst)
        s_ctrl_write ##1 s_ctrl_read
        |=> reg_rdata == ($past(reg_wdata, 2) & TRIG_CTRL0_MASK))
        else $error("control read did not return written value");

    a_reserved_read_zero : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        s_ctrl_read |=> (reg_rdata & ~TRIG_CTRL0_MASK) == '0)
        else $error("reserved control bits read nonzero");

    a_start_follows : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        any_event |-> s_event_seen)
        else $error("enabled event gave no start pulse");

    a_start_has_cause : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        adc_start |-> $past(any_event) && adc_trig_src != '0)
        else $error("start pulse without an event");

    a_ch3_lane : assert property ( // RULE1
        @(posedge clk_sys) disable iff (rst)
        (ev_all[CH3_ZERO_BIT] |-> $past(trig_ctrl[CH3_ZERO_BIT]))
        and (ev_all[CH3_UP_BIT] |-> $past(trig_ctrl[CH3_UP_BIT])))
        else $error("channel 3 event without its enable");

    a_ch2_lane : assert property ( // RULE2
        @(posedge clk_sys) disable iff (rst)
        (ev_all[CH2_ZERO_BIT] |-> $past(trig_ctrl[CH2_ZERO_BIT]))
        and (ev_all[CH2_UP_BIT] |-> $past(trig_ctrl[CH2_UP_BIT])))
        else $error("channel 2 event without its enable");

    a_ch1_lane : assert property ( // RULE3
        @(posedge clk_sys) disable iff (rst)
        (ev_all[CH1_ZERO_BIT] |-> $past(trig_ctrl[CH1_ZERO_BIT]))
        and (ev_all[CH1_UP_BIT] |-> $past(trig_ctrl[CH1_UP_BIT])))
        else $error("channel 1 event without its enable");

    a_ch0_lane : assert property ( // RULE4
        @(posedge clk_sys) disable iff (rst)
        (ev_all[CH0_ZERO_BIT] |-> $past(trig_ctrl[CH0_ZERO_BIT]))
        and (ev_all[CH0_UP_BIT] |-> $past(trig_ctrl[CH0_UP_BIT])))
        else $error("channel 0 event without its enable");

    a_zero_ch0_start : assert property ( // RULE5
        @(posedge clk_sys) disable iff (rst)
        (trig_ctrl[CH0_ZERO_BIT] && chan[0].count == '0
         && $past(chan[0].count) != '0)
        |=> ##1 adc_start)
        else $error("channel 0 zero match gave no start");

    a_edge_no_period : assert property ( // RULE9
        @(posedge clk_sys) disable iff (rst)
        (!chan[0].center_aligned && !chan[1].center_aligned
         && !chan[2].center_aligned && !chan[3].center_aligned)
        |=> ((ev_all & 32'h0303_0303) == '0))
        else $error("edge-aligned channel raised period or up event");

    a_zero_ch1_start : assert property ( // RULE5
        @(posedge clk_sys) disable iff (rst)
        (trig_ctrl[CH1_ZERO_BIT] && chan[1].count == '0
         && $past(chan[1].count) != '0)
        |=> ##1 adc_start)
        else $error("channel 1 zero match gave no start");

    a_zero_ch2_start : assert property ( // RULE5
        @(posedge clk_sys) disable iff (rst)
        (trig_ctrl[CH2_ZERO_BIT] && chan[2].count == '0
         && $past(chan[2].count) != '0)
        |=> ##1 adc_start)
        else $error("channel 2 zero match gave no start");

    a_zero_ch3_start : assert property ( // RULE5
        @(posedge clk_sys) disable iff (rst)
        (trig_ctrl[CH3_ZERO_BIT] && chan[3].count == '0
         && $past(chan[3].count) != '0)
        |=> ##1 adc_start)
        else $error("channel 3 zero match gave no start");

    a_ch3_mid_lane : assert property ( // RULE1
        @(posedge clk_sys) disable iff (rst)
        (ev_all[CH3_UP_BIT+EV_DOWN]
         |-> $past(trig_ctrl[CH3_UP_BIT+EV_DOWN]))
        and (ev_all[CH3_UP_BIT+EV_PERIOD]
             |-> $past(trig_ctrl[CH3_UP_BIT+EV_PERIOD])))
        else $error("channel 3 mid event without its enable");

    a_ch2_mid_lane : assert property ( // RULE2
        @(posedge clk_sys) disable iff (rst)
        (ev_all[CH2_UP_BIT+EV_DOWN]
         |-> $past(trig_ctrl[CH2_UP_BIT+EV_DOWN]))
        and (ev_all[CH2_UP_BIT+EV_PERIOD]
             |-> $past(trig_ctrl[CH2_UP_BIT+EV_PERIOD])))
        else $error("channel 2 mid event without its enable");

    a_ch1_mid_lane : assert property ( // RULE3
        @(posedge clk_sys) disable iff (rst)
        (ev_all[CH1_UP_BIT+EV_DOWN]
         |-> $past(trig_ctrl[CH1_UP_BIT+EV_DOWN]))
        and (ev_all[CH1_UP_BIT+EV_PERIOD]
             |-> $past(trig_ctrl[CH1_UP_BIT+EV_PERIOD])))
        else $error("channel 1 mid event without its enable");

    a_ch0_mid_lane : assert property ( // RULE4
        @(posedge clk_sys) disable iff (rst)
        (ev_all[CH0_UP_BIT+EV_DOWN]
         |-> $past(trig_ctrl[CH0_UP_BIT+EV_DOWN]))
        and (ev_all[CH0_UP_BIT+EV_PERIOD]
             |-> $past(trig_ctrl[CH0_UP_BIT+EV_PERIOD])))
        else $error("channel 0 mid event without its enable");

    a_ctrl_read_now : assert property ( // RULE10
        @(posedge clk_sys) disable iff (rst)
        s_ctrl_read |=> reg_rdata == $past(trig_ctrl))
        else $error("control read returned a stale value");

    a_rdata_idle_zero : assert property ( // RULE10
        @(posedge clk_sys) disable iff (rst)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside a read");

    a_unmapped_read_zero : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && !hit_ctrl && !hit_last && !hit_count)
        |=> reg_rdata == '0)
        else $error("unmapped read returned nonzero data");

    a_last_read_back : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        s_last_read |=> reg_rdata == $past(adc_trig_src))
        else $error("source read did not return last causes");

    a_count_read_back : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        s_count_read |=> reg_rdata == DATA_W'($past(trig_count)))
        else $error("count read did not return the tally");

    a_ctrl_hold : assert property ( // RULE10
        @(posedge clk_sys) disable iff (rst)
        !(reg_wr && hit_ctrl) |=> $stable(trig_ctrl))
        else $error("control register changed without a write");

    a_ctrl_reserved_zero : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        (trig_ctrl & ~TRIG_CTRL0_MASK) == '0)
        else $error("reserved control bits were stored");

    a_ev_reserved_zero : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        (ev_all & ~TRIG_CTRL0_MASK) == '0)
        else $error("event seen in a reserved lane");

    a_src_capture : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        any_event |=> adc_trig_src == $past(ev_all))
        else $error("source word missed the trigger causes");

    a_src_hold : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        !any_event |=> $stable(adc_trig_src))
        else $error("source word changed without a trigger");

    a_no_event_quiet : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        !any_event |=> !adc_start)
        else $error("start pulse without an enabled event");

    a_count_step : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        (any_event && !(reg_wr && hit_count))
        |=> trig_count == $past(trig_count) + TCNT_W'(1))
        else $error("trigger count did not advance");

    a_count_hold : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        (!any_event && !(reg_wr && hit_count)) |=> $stable(trig_count))
        else $error("trigger count changed without a trigger");

    a_count_clear : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && hit_count && !any_event)
        |=> trig_count == TRIG_COUNT_RESET)
        else $error("count write did not clear the tally");

    a_count_clear_hit : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && hit_count && any_event) |=> trig_count == TCNT_W'(1))
        else $error("trigger beside a clear was lost");

    a_count_clear_small : assert property ( // RULE11
        @(posedge clk_sys) disable iff (rst)
        s_count_clear |=> trig_count <= TCNT_W'(1))
        else $error("count write left a stale tally");

endmodule : pwm_adc_trigger_select
`default_nettype wire

// file: logic/trig_event_detect.sv
`timescale 1ns/10ps
`default_nettype none
module trig_event_detect (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire pwm_trig_pkg::pwm_chan_t      chan,
    input  wire logic [pwm_trig_pkg::EV_W-1:0] trig_en,
    output var  logic [pwm_trig_pkg::EV_W-1:0] event_pulse
);
    import pwm_trig_pkg::*;

    logic [EV_W-1:0] match;
    logic [EV_W-1:0] match_q;

    always_comb begin
        // RULE5 zero reach.
        match[EV_ZERO]   = (chan.count == '0);
        // RULE6 down compare.
        match[EV_DOWN]   = chan.count_down
                           && (chan.count == chan.compare_value);
        // RULE7 period match.
        // RULE9 edge mode blocks.
        match[EV_PERIOD] = chan.center_aligned
                           && (chan.count == chan.period_value);
        // RULE8 up compare.
        match[EV_UP]     = chan.center_aligned && !chan.count_down
                           && (chan.count == chan.compare_value);
    end

    // A prescaled counter may dwell on one value for many cycles, so only
    // the first cycle of a match counts as an event.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            match_q <= '0;
        end else begin
            match_q <= match;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            event_pulse <= '0;
        end else begin
            event_pulse <= trig_en & match & ~match_q;
        end
    end

    a_zero_event_fires : assert property ( // RULE5
        @(posedge clk_sys) disable iff (rst)
        (trig_en[EV_ZERO] && chan.count == '0 && !match_q[EV_ZERO])
        |=> event_pulse[EV_ZERO])
        else $error("zero match did not raise its event");

    a_down_event_fires : assert property ( // RULE6
        @(posedge clk_sys) disable iff (rst)
        (trig_en[EV_DOWN] && chan.count_down
         && chan.count == chan.compare_value && !match_q[EV_DOWN])
        |=> event_pulse[EV_DOWN])
        else $error("down compare did not raise its event");

    a_period_center : assert property ( // RULE7
        @(posedge clk_sys) disable iff (rst)
        (trig_en[EV_PERIOD] && chan.center_aligned
         && chan.count == chan.period_value && !match_q[EV_PERIOD])
        |=> event_pulse[EV_PERIOD])
        else $error("period match missed in center mode");

    a_up_center : assert property ( // RULE8
        @(posedge clk_sys) disable iff (rst)
        (trig_en[EV_UP] && chan.center_aligned && !chan.count_down
         && chan.count == chan.compare_value && !match_q[EV_UP])
        |=> event_pulse[EV_UP])
        else $error("up compare missed in center mode");

    a_edge_mode_mute : assert property ( // RULE9
        @(posedge clk_sys) disable iff (rst)
        !chan.center_aligned
        |=> !event_pulse[EV_PERIOD] && !event_pulse[EV_UP])
        else $error("edge mode raised a period or up event");

endmodule : trig_event_detect
`default_nettype wire

// file: shared/pwm_trig_pkg.sv
`default_nettype none
package pwm_trig_pkg;

    localparam int NUM_CH = 4;
    localparam int CNT_W  = 16;
    localparam int EV_W   = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TCNT_W = 16;

    // Byte offsets of the register words.
    localparam logic [ADDR_W-1:0] TRIG_CTRL0_OFFSET = 8'h68;
    localparam logic [ADDR_W-1:0] TRIG_LAST_OFFSET  = 8'h70;
    localparam logic [ADDR_W-1:0] TRIG_COUNT_OFFSET = 8'h74;

    localparam logic [DATA_W-1:0] TRIG_CTRL0_RESET  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] TRIG_CTRL0_MASK   = 32'h0f0f_0f0f;
    localparam logic [TCNT_W-1:0] TRIG_COUNT_RESET  = 16'h0000;

    // Each channel owns one byte lane; the four enables sit in its low nibble.
    localparam int CH_STRIDE = 8;
    localparam int EV_UP     = 0;
    localparam int EV_PERIOD = 1;
    localparam int EV_DOWN   = 2;
    localparam int EV_ZERO   = 3;

    // Field positions for each channel's zero-match and up-count compare enables.
    localparam int CH3_ZERO_BIT = 27;
    localparam int CH2_ZERO_BIT = 19;
    localparam int CH1_ZERO_BIT = 11;
    localparam int CH0_ZERO_BIT = 3;
    localparam int CH3_UP_BIT   = 24;
    localparam int CH2_UP_BIT   = 16;
    localparam int CH1_UP_BIT   = 8;
    localparam int CH0_UP_BIT   = 0;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] compare_value;
        logic [CNT_W-1:0] period_value;
        logic             count_down;
        logic             center_aligned;
    } pwm_chan_t;

endpackage : pwm_trig_pkg
`default_nettype wire

// file: sim/adc_start_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_start_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        adc_start,
    input  wire logic [31:0] adc_trig_src,
    output var  logic [15:0] conv_count,
    output var  logic [31:0] conv_src
);
    // Only a cycle with the start pulse high counts as one conversion.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conv_count <= 16'h0000;
            conv_src   <= 32'h0000_0000;
        end else if (adc_start) begin
            conv_count <= conv_count + 16'h0001;
            conv_src   <= adc_trig_src;
        end
    end
endmodule : adc_start_model
`default_nettype wire

// file: sim/pwm_adc_trigger_select_test.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_adc_trigger_select_test;
    import pwm_trig_pkg::*;
    logic              clk_sys;
    logic              rst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    pwm_chan_t         chan [NUM_CH];
    logic              adc_start;
    logic [DATA_W-1:0] adc_trig_src;
    logic [15:0]       conv_count;
    logic [31:0]       conv_src;
    logic [31:0]       rd_val;
    int                failures;
    int                checks_done;
    int                pulses;

    pwm_adc_trigger_select i_pwm_adc_trigger_select (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .chan(chan), .adc_start(adc_start),
        .adc_trig_src(adc_trig_src));
    adc_start_model i_adc_start_model (
        .clk_sys(clk_sys), .rst(rst), .adc_start(adc_start),
        .adc_trig_src(adc_trig_src), .conv_count(conv_count),
        .conv_src(conv_src));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Compare and period stay fixed at 3 and 9; idle count is 5.
    function automatic pwm_chan_t mk(input logic [15:0] cnt,
                                     input logic dn, input logic cen);
        return '{cnt, 16'h0003, 16'h0009, dn, cen};
    endfunction : mk

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // Write then read back with no idle cycle between the strobes.
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask : wr_rd

    task automatic set_all(input logic cen);
        @(posedge clk_sys);
        for (int i = 0; i < NUM_CH; i++) chan[i] <= mk(16'h0005, 1'b0, cen);
    endtask : set_all

    // Event 0 up, 1 period, 2 down, 3 zero; one-cycle match at count.
    task automatic fire(input int ch, input int ev, input logic cen,
                        input logic hit);
        logic [15:0] cnt;
        logic        dn;
        cnt = (ev == 3) ? 16'h0000 : (ev == 1) ? 16'h0009 : 16'h0003;
        dn  = (ev >= 2);
        @(posedge clk_sys);
        chan[ch] <= mk(cnt, dn, cen);
        @(posedge clk_sys);
        chan[ch] <= mk(16'h0005, 1'b0, cen);
        @(posedge clk_sys) #1;
        check("adc_start", adc_start, hit);
        if (hit) check("adc_trig_src", adc_trig_src, 32'h1 << (8*ch+ev));
        @(posedge clk_sys) #1;
        check("adc_start width", adc_start, 1'b0);
        pulses += int'(hit);
    endtask : fire

    task automatic test_regs;
        logic [7:0] addrs [3] = '{8'h68, 8'h6c, 8'h00};
        foreach (addrs[i]) begin
            rd(addrs[i], rd_val);
            check("reset read", rd_val, 32'h0000_0000);
        end
        wr(8'h6c, 32'hffff_ffff);
        wr_rd(8'h68, 32'hffff_ffff, rd_val);
        check("ctrl readback", rd_val, 32'h0f0f_0f0f);
        rd(8'h6c, rd_val);
        check("unmapped read", rd_val, 32'h0000_0000);
    endtask : test_regs

    // A single enable fires; every other enable set must not.
    task automatic test_center;
        logic [31:0] b;
        set_all(1'b1);
        for (int ch = 0; ch < 4; ch++) for (int ev = 0; ev < 4; ev++) begin
            b = 32'h1 << (8*ch+ev);
            wr(8'h68, b);
            fire(ch, ev, 1'b1, 1'b1);
            wr(8'h68, 32'h0f0f_0f0f ^ b);
            fire(ch, ev, 1'b1, 1'b0);
        end
    endtask : test_center

    task automatic test_edge;
        set_all(1'b0);
        wr(8'h68, 32'h0f0f_0f0f);
        for (int ch = 0; ch < 4; ch++) for (int ev = 0; ev < 4; ev++)
            fire(ch, ev, 1'b0, ev >= 2);
    endtask : test_edge

    // Two channels at once, held: one merged pulse, no refire.
    task automatic test_merge;
        wr(8'h68, 32'h0008_0008);
        @(posedge clk_sys);
        chan[0] <= mk(16'h0000, 1'b1, 1'b0);
        chan[2] <= mk(16'h0000, 1'b1, 1'b0);
        repeat (2) @(posedge clk_sys);
        #1;
        check("merged start", adc_start, 1'b1);
        check("merged src", adc_trig_src, 32'h0008_0008);
        repeat (2) begin
            @(posedge clk_sys) #1;
            check("held match", adc_start, 1'b0);
        end
        pulses++;
        set_all(1'b0);
        rd(8'h74, rd_val);
        check("trigger count", rd_val, pulses);
        rd(8'h70, rd_val);
        check("last source", rd_val, 32'h0008_0008);
        check("model count", {16'h0000, conv_count}, pulses);
        check("model src", conv_src, 32'h0008_0008);
    endtask : test_merge

    // Clear alone, then a clear in the very cycle of a trigger.
    task automatic test_count_clear;
        wr(8'h74, 32'h0000_0000);
        rd(8'h74, rd_val);
        check("cleared count", rd_val, 32'h0000_0000);
        @(posedge clk_sys);
        chan[0] <= mk(16'h0000, 1'b1, 1'b0);
        @(posedge clk_sys);
        chan[0]   <= mk(16'h0005, 1'b0, 1'b0);
        reg_wr    <= 1'b1;
        reg_addr  <= 8'h74;
        reg_wdata <= 32'h0000_0000;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        rd(8'h74, rd_val);
        check("clear beside trigger", rd_val, 32'h0000_0001);
    endtask : test_count_clear

    initial begin
        #1_000_000;
        failures++;
        test_done();
    end

    initial begin
        rst       = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        for (int i = 0; i < NUM_CH; i++) chan[i] = mk(16'h0005, 1'b0, 1'b0);
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        test_regs();
        test_center();
        test_edge();
        test_merge();
        test_count_clear();
        test_done();
    end
endmodule : pwm_adc_trigger_select_test
`default_nettype wire
